/* File: hdl/jtc_defs.svh */
// Constants shared by the test access port design
`ifndef JTC_DEFS_SVH
`define JTC_DEFS_SVH

// Instruction register width, at least two cells
`define JTC_IR_WIDTH 2
// Boundary-scan register length, one cell per component pin
`define JTC_BSR_WIDTH 8
// Consecutive high mode-select clocks that force Reset
`define JTC_RESET_TMS_CLOCKS 5
// Instruction codes: all ones is bypass, all zeros drives pins
`define JTC_OP_SAMPLE 1
// Pattern loaded into the instruction shifter in Capture-IR
`define JTC_IR_CAPTURE 1

`endif

/* File: hdl/jtc_pkg.sv */
// Types for the test access port design
package jtc_pkg;

	// Sixteen controller states
	typedef enum logic [3:0] {
		JTC_RESET,
		JTC_IDLE,
		JTC_DR_SCAN,
		JTC_CAPTURE_DR,
		JTC_SHIFT_DR,
		JTC_EXIT1_DR,
		JTC_PAUSE_DR,
		JTC_EXIT2_DR,
		JTC_UPDATE_DR,
		JTC_IR_SCAN,
		JTC_CAPTURE_IR,
		JTC_SHIFT_IR,
		JTC_EXIT1_IR,
		JTC_PAUSE_IR,
		JTC_EXIT2_IR,
		JTC_UPDATE_IR
	} jtc_state_type;

	// Data register placed between serial in and serial out
	typedef enum logic [0:0] {
		JTC_SEL_BYPASS,
		JTC_SEL_BOUNDARY
	} jtc_sel_type;

endpackage

/* File: hdl/jtc_scan_reg.sv */
// Capture, shift and update register with a parallel output latch
`timescale 1ns/10ps
module jtc_scan_reg #(
	parameter int WIDTH = 2,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic i_clear,
	input wire logic i_capture,
	input wire logic i_shift,
	input wire logic i_update,
	input wire logic i_tdi,
	input wire logic [WIDTH-1:0] i_capture_data,
	output logic [WIDTH-1:0] o_shift_data,
	output logic [WIDTH-1:0] o_update_data
);

	// A register with no cells would leave nothing to shift or latch
	if (WIDTH < 1) begin : g_bad_width
		$error("jtc_scan_reg: WIDTH must be at least 1");
	end

	// Shift stage: serial data walks toward bit 0, which feeds the output
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			o_shift_data <= '0;
		end else if (i_capture) begin
			o_shift_data <= i_capture_data;
		end else if (i_shift) begin
			// One expression for every width, so a single cell needs no reversed slice
			o_shift_data <= WIDTH'({i_tdi, o_shift_data} >> 1);
		end
	end

	// Update latch only moves on update or clear, so shifting never disturbs it
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			o_update_data <= RESET_VALUE;
		end else if (i_clear) begin
			o_update_data <= RESET_VALUE;
		end else if (i_update) begin
			o_update_data <= o_shift_data;
		end
	end

endmodule

/* File: hdl/jtc_tap.sv */
// Test access port: controller, instruction, bypass and boundary registers
//
// What this block does
// - Pins are clock, mode, data in, data out, reset.
// - Synchronous controller decodes mode-select on test clock.
// - Five high mode-select clocks always reach Reset.
// - Reset holds while mode-select stays high.
// - Test logic inactive while in Reset.
// - Idle holds while mode-select stays low.
// - DR-Scan with low mode-select enters Capture-DR.
// - IR-Scan with low mode-select enters Capture-IR.
// - Capture-DR loads selected register in parallel.
// - Shift-DR moves data register toward output.
// - Pause-DR holds data register contents.
// - Exit2-DR returns to Shift or goes Update.
// - Update-DR latches data; latch steady while shifting.
// - Capture-IR loads instruction shifter in parallel.
// - Shift-IR moves instruction shifter toward output.
// - Pause-IR holds instruction shifter contents.
// - Exit2-IR returns to Shift or goes Update.
// - Update-IR latches new current instruction.
// - Instruction has two cells, selects test.
// - Bypass and boundary-scan registers both exist.
// - Bypass is one bit from input to output.
// - Boundary register reaches component inputs and outputs.
`timescale 1ns/10ps
`include "jtc_defs.svh"
module jtc_tap #(
	parameter int IR_WIDTH = `JTC_IR_WIDTH,
	parameter int BSR_WIDTH = `JTC_BSR_WIDTH
) (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic i_tck,
	input wire logic i_tms,
	input wire logic i_tdi,
	input wire logic i_trst_n,
	input wire logic [BSR_WIDTH-1:0] i_pin_capture,
	output logic o_tdo,
	output logic o_tdo_oe_n,
	output logic [BSR_WIDTH-1:0] o_pin_drive,
	output logic o_pin_drive_en,
	output logic o_test_active,
	output jtc_pkg::jtc_state_type o_state
);
	import jtc_pkg::*;

	// Fewer than two instruction cells cannot hold the three codes
	if (IR_WIDTH < 2) begin : g_bad_ir
		$error("jtc_tap: IR_WIDTH must be at least 2");
	end
	if (BSR_WIDTH < 1) begin : g_bad_bsr
		$error("jtc_tap: BSR_WIDTH must be at least 1");
	end

	localparam logic [IR_WIDTH-1:0] OP_EXTEST = '0;
	localparam logic [IR_WIDTH-1:0] OP_SAMPLE = IR_WIDTH'(`JTC_OP_SAMPLE);
	localparam logic [IR_WIDTH-1:0] OP_BYPASS = '1;
	localparam logic [IR_WIDTH-1:0] IR_CAPTURE = IR_WIDTH'(`JTC_IR_CAPTURE);

	// Optional test reset pin initialises the port without the clock
	logic rst_n;
	assign rst_n = i_resetn & i_trst_n;

	// Pins cross into i_clock through two flops before anything looks at them
	logic tck_s1;
	logic tck_s2;
	logic tck_s3;
	logic tms_s1;
	logic tms_s2;
	logic tdi_s1;
	logic tdi_s2;
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			tck_s1 <= 1'b0;
			tck_s2 <= 1'b0;
			tck_s3 <= 1'b0;
			tms_s1 <= 1'b1;
			tms_s2 <= 1'b1;
			tdi_s1 <= 1'b1;
			tdi_s2 <= 1'b1;
		end else begin
			tck_s1 <= i_tck;
			tck_s2 <= tck_s1;
			tck_s3 <= tck_s2;
			tms_s1 <= i_tms;
			tms_s2 <= tms_s1;
			tdi_s1 <= i_tdi;
			tdi_s2 <= tdi_s1;
		end
	end

	// Edge strobes; mode and data share the clock's latency so they line up
	logic tck_rise;
	logic tck_fall;
	assign tck_rise = tck_s2 & ~tck_s3;
	assign tck_fall = ~tck_s2 & tck_s3;

	// Next state for the standard graph
	function automatic jtc_state_type next_tap(input jtc_state_type s, input logic m);
		case (s)
			JTC_RESET: next_tap = m ? JTC_RESET : JTC_IDLE;
			JTC_IDLE: next_tap = m ? JTC_DR_SCAN : JTC_IDLE;
			JTC_DR_SCAN: next_tap = m ? JTC_IR_SCAN : JTC_CAPTURE_DR;
			JTC_CAPTURE_DR: next_tap = m ? JTC_EXIT1_DR : JTC_SHIFT_DR;
			JTC_SHIFT_DR: next_tap = m ? JTC_EXIT1_DR : JTC_SHIFT_DR;
			JTC_EXIT1_DR: next_tap = m ? JTC_UPDATE_DR : JTC_PAUSE_DR;
			JTC_PAUSE_DR: next_tap = m ? JTC_EXIT2_DR : JTC_PAUSE_DR;
			JTC_EXIT2_DR: next_tap = m ? JTC_UPDATE_DR : JTC_SHIFT_DR;
			JTC_UPDATE_DR: next_tap = m ? JTC_DR_SCAN : JTC_IDLE;
			JTC_IR_SCAN: next_tap = m ? JTC_RESET : JTC_CAPTURE_IR;
			JTC_CAPTURE_IR: next_tap = m ? JTC_EXIT1_IR : JTC_SHIFT_IR;
			JTC_SHIFT_IR: next_tap = m ? JTC_EXIT1_IR : JTC_SHIFT_IR;
			JTC_EXIT1_IR: next_tap = m ? JTC_UPDATE_IR : JTC_PAUSE_IR;
			JTC_PAUSE_IR: next_tap = m ? JTC_EXIT2_IR : JTC_PAUSE_IR;
			JTC_EXIT2_IR: next_tap = m ? JTC_UPDATE_IR : JTC_SHIFT_IR;
			JTC_UPDATE_IR: next_tap = m ? JTC_DR_SCAN : JTC_IDLE;
			default: next_tap = JTC_RESET;
		endcase
	endfunction

	// Controller steps once per test clock rising edge
	jtc_state_type state;
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= JTC_RESET;
		end else if (tck_rise) begin
			state <= next_tap(state, tms_s2);
		end
	end
	assign o_state = state;

	// Instruction register; Reset forces bypass so the pins stay untouched
	logic [IR_WIDTH-1:0] ir_shift;
	logic [IR_WIDTH-1:0] ir_current;
	jtc_scan_reg #(
		.WIDTH(IR_WIDTH),
		.RESET_VALUE(OP_BYPASS)
	) u_ir (
		.i_clock(i_clock),
		.i_resetn(rst_n),
		.i_clear(state == JTC_RESET),
		.i_capture(tck_rise && state == JTC_CAPTURE_IR),
		.i_shift(tck_rise && state == JTC_SHIFT_IR),
		.i_update(tck_rise && state == JTC_UPDATE_IR),
		.i_tdi(tdi_s2),
		.i_capture_data(IR_CAPTURE),
		.o_shift_data(ir_shift),
		.o_update_data(ir_current)
	);

	// Current instruction picks the data register; unknown codes fall to bypass
	function automatic jtc_sel_type dr_select(input logic [IR_WIDTH-1:0] op);
		if (op == OP_EXTEST || op == OP_SAMPLE) begin
			dr_select = JTC_SEL_BOUNDARY;
		end else begin
			dr_select = JTC_SEL_BYPASS;
		end
	endfunction

	logic dr_capture;
	logic dr_shift;
	logic dr_update;
	assign dr_capture = tck_rise && state == JTC_CAPTURE_DR;
	assign dr_shift = tck_rise && state == JTC_SHIFT_DR;
	assign dr_update = tck_rise && state == JTC_UPDATE_DR;

	// Boundary register captures pin levels and latches values to drive
	logic [BSR_WIDTH-1:0] bsr_shift;
	jtc_scan_reg #(
		.WIDTH(BSR_WIDTH),
		.RESET_VALUE('0)
	) u_bsr (
		.i_clock(i_clock),
		.i_resetn(rst_n),
		.i_clear(1'b0),
		.i_capture(dr_capture && dr_select(ir_current) == JTC_SEL_BOUNDARY),
		.i_shift(dr_shift && dr_select(ir_current) == JTC_SEL_BOUNDARY),
		.i_update(dr_update && dr_select(ir_current) == JTC_SEL_BOUNDARY),
		.i_tdi(tdi_s2),
		.i_capture_data(i_pin_capture),
		.o_shift_data(bsr_shift),
		.o_update_data(o_pin_drive)
	);

	// One-bit bypass cell; capture clears it as the standard path expects
	logic bypass_bit;
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			bypass_bit <= 1'b0;
		end else if (dr_capture && dr_select(ir_current) == JTC_SEL_BYPASS) begin
			bypass_bit <= 1'b0;
		end else if (dr_shift && dr_select(ir_current) == JTC_SEL_BYPASS) begin
			bypass_bit <= tdi_s2;
		end
	end

	// Serial output changes only on the falling test clock edge
	logic next_tdo;
	always_comb begin
		if (state == JTC_SHIFT_IR) begin
			next_tdo = ir_shift[0];
		end else if (dr_select(ir_current) == JTC_SEL_BOUNDARY) begin
			next_tdo = bsr_shift[0];
		end else begin
			next_tdo = bypass_bit;
		end
	end
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			o_tdo <= 1'b1;
			o_tdo_oe_n <= 1'b1;
		end else if (tck_fall) begin
			o_tdo <= next_tdo;
			o_tdo_oe_n <= !(state == JTC_SHIFT_DR || state == JTC_SHIFT_IR);
		end
	end

	// Pins are only taken over under the drive instruction, never in Reset
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			o_pin_drive_en <= 1'b0;
			o_test_active <= 1'b0;
		end else begin
			o_pin_drive_en <= (ir_current == OP_EXTEST) && state != JTC_RESET;
			o_test_active <= state != JTC_RESET;
		end
	end

	// Helper: run of consecutive high mode-select samples, saturating
	logic [2:0] tms_ones;
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			tms_ones <= 3'h0;
		end else if (tck_rise) begin
			if (!tms_s2) begin
				tms_ones <= 3'h0;
			end else if (tms_ones != 3'h7) begin
				tms_ones <= tms_ones + 3'h1;
			end
		end
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!rst_n);

	// Steps of a behaviour are named so each property reads as cause and effect
	sequence s_rise_low;
		tck_rise && !tms_s2;
	endsequence
	sequence s_held_reset;
		state == JTC_RESET ##1 state == JTC_RESET;
	endsequence
	sequence s_held_pause_dr;
		state == JTC_PAUSE_DR ##1 state == JTC_PAUSE_DR;
	endsequence
	sequence s_held_pause_ir;
		state == JTC_PAUSE_IR ##1 state == JTC_PAUSE_IR;
	endsequence

	// Controller graph
	a_reset_forced: assert property (tms_ones >= 3'(`JTC_RESET_TMS_CLOCKS) |-> state == JTC_RESET)
		else $error("five high mode-select clocks did not reach Reset");
	a_reset_hold: assert property (tck_rise && tms_s2 && state == JTC_RESET |=> state == JTC_RESET)
		else $error("Reset left while mode-select high");
	a_idle_hold: assert property (s_rise_low ##0 state == JTC_IDLE |=> state == JTC_IDLE)
		else $error("Idle left while mode-select low");
	a_dr_scan_enter: assert property (s_rise_low ##0 state == JTC_DR_SCAN |=> state == JTC_CAPTURE_DR)
		else $error("DR-Scan did not enter Capture-DR");
	a_ir_scan_enter: assert property (s_rise_low ##0 state == JTC_IR_SCAN |=> state == JTC_CAPTURE_IR)
		else $error("IR-Scan did not enter Capture-IR");
	a_exit2_dr_route: assert property (tck_rise && state == JTC_EXIT2_DR
		|=> state == ($past(tms_s2) ? JTC_UPDATE_DR : JTC_SHIFT_DR))
		else $error("Exit2-DR went the wrong way");
	a_exit2_ir_route: assert property (tck_rise && state == JTC_EXIT2_IR
		|=> state == ($past(tms_s2) ? JTC_UPDATE_IR : JTC_SHIFT_IR))
		else $error("Exit2-IR went the wrong way");

	// Data registers
	a_pause_dr_hold: assert property (s_held_pause_dr |-> $stable(bsr_shift) && $stable(bypass_bit))
		else $error("data register moved during Pause-DR");
	a_bsr_shift_in: assert property (dr_shift && dr_select(ir_current) == JTC_SEL_BOUNDARY
		|=> bsr_shift[BSR_WIDTH-1] == $past(tdi_s2))
		else $error("boundary register did not take serial input");
	a_dr_latch_steady: assert property (!dr_update |=> $stable(o_pin_drive))
		else $error("boundary latch moved outside Update-DR");
	a_bypass_path: assert property (dr_shift && dr_select(ir_current) == JTC_SEL_BYPASS
		|=> bypass_bit == $past(tdi_s2))
		else $error("bypass cell did not take serial input");

	// Instruction register
	a_ir_capture_load: assert property (tck_rise && state == JTC_CAPTURE_IR |=> ir_shift == IR_CAPTURE)
		else $error("instruction shifter not loaded in Capture-IR");
	a_ir_shift_in: assert property (tck_rise && state == JTC_SHIFT_IR
		|=> ir_shift[IR_WIDTH-1] == $past(tdi_s2))
		else $error("instruction shifter did not take serial input");
	a_pause_ir_hold: assert property (s_held_pause_ir |-> $stable(ir_shift))
		else $error("instruction shifter moved during Pause-IR");
	a_ir_latch_steady: assert property (!(tck_rise && state == JTC_UPDATE_IR) && state != JTC_RESET
		|=> $stable(ir_current))
		else $error("current instruction changed outside Update-IR");

	// Serial output and pins; the enable must follow the state seen at the fall
	a_tdo_enable: assert property (tck_fall && (state == JTC_SHIFT_DR || state == JTC_SHIFT_IR)
		|=> !o_tdo_oe_n && o_tdo == $past(next_tdo))
		else $error("serial output not enabled in shift state");
	a_tdo_disable: assert property (tck_fall && !(state == JTC_SHIFT_DR || state == JTC_SHIFT_IR)
		|=> o_tdo_oe_n)
		else $error("serial output enabled outside shift states");
	a_tdo_steady: assert property (!tck_fall |=> $stable(o_tdo) && $stable(o_tdo_oe_n))
		else $error("serial output changed away from a test clock fall");
	a_pin_release: assert property (s_held_reset |=> !o_pin_drive_en)
		else $error("pins driven while in Reset");
	a_test_inactive: assert property (state == JTC_RESET |=> !o_test_active)
		else $error("test logic active while in Reset");

endmodule

/* File: dv/jtc_probe.sv */
// Behavioural test controller that clocks the port and samples its serial output
`timescale 1ns/10ps
module jtc_probe (
	output logic o_tck,
	output logic o_tms,
	output logic o_tdi,
	input wire logic i_tdo
);
	// Clock stands low between frames so the port sees no stray edge
	initial begin
		o_tck = 1'b0;
		o_tms = 1'b1;
		o_tdi = 1'b0;
	end

	// One 125 ns test clock: set pins while low, sample output just before the rise
	task automatic step(input logic tms, input logic tdi, output logic tdo);
		o_tms = tms;
		o_tdi = tdi;
		#62.5;
		tdo = i_tdo;
		o_tck = 1'b1;
		#62.5;
		o_tck = 1'b0;
	endtask
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the test access port
`timescale 1ns/10ps
`include "jtc_defs.svh"
module testbench;
	import jtc_pkg::*;
	logic i_clock, i_resetn, i_trst_n, tck, tms, tdi, tdo, o_tdo, o_tdo_oe_n, o_pin_drive_en, o_test_active;
	logic [7:0] i_pin_capture, o_pin_drive, q;
	jtc_state_type o_state;
	int fails = 0;
	int n_compared = 0;

	// Line is pulled up while the port leaves it undriven
	assign tdo = o_tdo_oe_n ? 1'b1 : o_tdo;

	jtc_tap DUT (.i_clock(i_clock), .i_resetn(i_resetn), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
		.i_trst_n(i_trst_n), .i_pin_capture(i_pin_capture), .o_tdo(o_tdo), .o_tdo_oe_n(o_tdo_oe_n),
		.o_pin_drive(o_pin_drive), .o_pin_drive_en(o_pin_drive_en), .o_test_active(o_test_active),
		.o_state(o_state));
	jtc_probe probe (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo));

	// 100 MHz system clock
	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end

	// Compare tasks, one per kind of result
	task automatic chk_st(input jtc_state_type exp);
		n_compared++;
		if (o_state !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, o_state, exp);
		end
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Re-align off the system clock edge so test clock edges never meet it
	task automatic sync(input int n);
		repeat (n) @(posedge i_clock);
		#2;
	endtask
	// Bit i of the vector is the mode-select value for step i
	task automatic walk(input logic [7:0] v, input int n);
		logic b;
		for (int i = 0; i < n; i++) begin
			probe.step(v[i], 1'b0, b);
		end
	endtask
	// Shift n bits LSB first, leaving the shift state on the last one
	task automatic shft(input int n, input logic [7:0] din, output logic [7:0] dout);
		logic b;
		dout = 8'h00;
		for (int i = 0; i < n; i++) begin
			probe.step(i == n - 1, din[i], b);
			dout[i] = b;
		end
	endtask
	// Instruction load from Idle with a pause between the two bits
	task automatic load_ir(input logic [1:0] code);
		logic [7:0] o1, o2;
		walk(8'h03, 4);
		chk_st(JTC_SHIFT_IR);
		shft(1, {7'h0, code[0]}, o1);
		walk(8'h00, 1);
		chk_st(JTC_PAUSE_IR);
		walk(8'h01, 2);
		chk_st(JTC_SHIFT_IR);
		shft(1, {7'h0, code[1]}, o2);
		walk(8'h01, 2);
		chk_st(JTC_IDLE);
		chk({6'h0, o2[0], o1[0]}, 8'(`JTC_IR_CAPTURE));
	endtask

	// Reset leaves the component alone; Idle holds on low mode-select
	task automatic t_reset();
		chk_st(JTC_RESET);
		chk({5'h0, o_tdo_oe_n, o_test_active, o_pin_drive_en}, 8'h04);
		walk(8'h00, 4);
		chk_st(JTC_IDLE);
		chk({7'h0, o_test_active}, 8'h01);
		$display("test reset done");
	endtask
	// Four high clocks are not enough from Shift-DR, the fifth is
	task automatic t_five();
		walk(8'h01, 3);
		chk_st(JTC_SHIFT_DR);
		sync(5);
		chk({7'h0, o_tdo_oe_n}, 8'h00);
		walk(8'h0f, 4);
		chk_st(JTC_IR_SCAN);
		walk(8'h01, 1);
		chk_st(JTC_RESET);
		walk(8'hff, 8);
		chk_st(JTC_RESET);
		walk(8'h00, 1);
		sync(5);
		chk({7'h0, o_tdo_oe_n}, 8'h01);
		$display("test five_ones done");
	endtask
	// Boundary capture, paused shift and update under the sampling code
	task automatic t_sample();
		logic [7:0] lo, hi;
		load_ir(2'(`JTC_OP_SAMPLE));
		@(posedge i_clock);
		i_pin_capture <= 8'ha5;
		#2;
		walk(8'h01, 3);
		shft(4, 8'h0c, lo);
		walk(8'h00, 2);
		chk_st(JTC_PAUSE_DR);
		walk(8'h01, 2);
		chk_st(JTC_SHIFT_DR);
		shft(4, 8'h03, hi);
		chk(o_pin_drive, 8'h00);
		chk({hi[3:0], lo[3:0]}, 8'ha5);
		walk(8'h01, 2);
		chk(o_pin_drive, 8'h3c);
		chk({7'h0, o_pin_drive_en}, 8'h00);
		$display("test sample done");
	endtask
	// Pin-driving code, then one-bit bypass path
	task automatic t_extest();
		load_ir(2'b00);
		chk({7'h0, o_pin_drive_en}, 8'h01);
		chk(o_pin_drive, 8'h3c);
		load_ir(2'b11);
		chk({7'h0, o_pin_drive_en}, 8'h00);
		walk(8'h01, 3);
		shft(4, 8'h0b, q);
		chk(q, 8'h06);
		walk(8'h01, 2);
		chk(o_pin_drive, 8'h3c);
		load_ir(2'b10);
		chk({7'h0, o_pin_drive_en}, 8'h00);
		walk(8'h01, 3);
		shft(2, 8'h01, q);
		chk(q, 8'h02);
		walk(8'h01, 2);
		$display("test extest_bypass done");
	endtask
	// Test reset pin clears the port mid-scan and restores bypass
	task automatic t_trst();
		walk(8'h03, 4);
		@(posedge i_clock);
		i_trst_n <= 1'b0;
		sync(3);
		chk_st(JTC_RESET);
		chk(o_pin_drive, 8'h00);
		@(posedge i_clock);
		i_trst_n <= 1'b1;
		sync(4);
		walk(8'h02, 4);
		shft(2, 8'h01, q);
		chk(q, 8'h02);
		walk(8'h01, 2);
		$display("test trst done");
	endtask

	// Closing report and verdict
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Main sequence: 20 cycles of reset, then the scenarios in turn
	initial begin
		i_resetn = 1'b0;
		i_trst_n = 1'b1;
		i_pin_capture = 8'h00;
		repeat (20) @(posedge i_clock);
		i_resetn <= 1'b1;
		sync(4);
		t_reset();
		t_five();
		t_sample();
		t_extest();
		t_trst();
		print_verdict();
	end
endmodule
